// ---- logic/rlc_pkg.sv ----
/*
  rlc_pkg: constants for the record-path level control block.
  Assumes: 7-bit register addresses, byte-wide registers, levels in dB below full scale.
*/
package rlc_pkg;
  // register addresses on the serial control port
  localparam logic [6:0] ADDR_CFG_A   = 7'h7b;
  localparam logic [6:0] ADDR_CFG_B   = 7'h7c;
  localparam logic [6:0] ADDR_RESTART = 7'h7d;
  localparam logic [7:0] CFG_A_RESET  = 8'h00;
  localparam logic [7:0] CFG_B_RESET  = 8'h00;
  localparam logic [7:0] RDATA_NONE   = 8'h00;
  // held level after reset: far below any threshold, so the controller starts quiet
  localparam logic [7:0] LEVEL_QUIET  = 8'hff;

  // field positions, config a
  localparam int RATE_LSB   = 6;
  localparam int LIMIT_LSB  = 4;
  localparam int MODE_LSB   = 2;
  localparam int POLICY_BIT = 1;
  localparam int ENABLE_BIT = 0;
  // field positions, config b
  localparam int RTH_LSB    = 5;
  localparam int ATH_LSB    = 3;
  localparam int RTIME_LSB  = 1;
  localparam int ATIME_BIT  = 0;
  localparam int RESV_BIT   = 7;

  // rate codes and samples per millisecond
  localparam logic [1:0] RATE_96   = 2'h0;
  localparam logic [1:0] RATE_48   = 2'h1;
  localparam logic [1:0] RATE_32   = 2'h2;
  localparam logic [1:0] RATE_RSVD = 2'h3;
  localparam logic [6:0] SPMS_96   = 7'h60;
  localparam logic [6:0] SPMS_48   = 7'h30;
  localparam logic [6:0] SPMS_32   = 7'h20;

  // recovery modes
  localparam logic [1:0] MODE_NONE    = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h1;
  localparam logic [1:0] MODE_LIMITED = 2'h2;

  // limited-recovery counter limits
  localparam logic [4:0] LIMIT_0 = 5'h03;
  localparam logic [4:0] LIMIT_1 = 5'h07;
  localparam logic [4:0] LIMIT_2 = 5'h0f;
  localparam logic [4:0] LIMIT_3 = 5'h1f;

  // thresholds, dB below full scale
  localparam logic [7:0] ATK_DB_0 = 8'h00;
  localparam logic [7:0] ATK_DB_1 = 8'h01;
  localparam logic [7:0] ATK_DB_2 = 8'h02;
  localparam logic [7:0] ATK_DB_3 = 8'h04;
  localparam logic [7:0] REC_DB_0 = 8'h02;
  localparam logic [7:0] REC_DB_1 = 8'h03;
  localparam logic [7:0] REC_DB_2 = 8'h04;
  localparam logic [7:0] REC_DB_3 = 8'h06;

  // timing in milliseconds
  localparam logic [8:0] ATK_MS_0 = 9'h001;
  localparam logic [8:0] ATK_MS_1 = 9'h004;
  localparam logic [8:0] REC_MS_0 = 9'h020;
  localparam logic [8:0] REC_MS_1 = 9'h040;
  localparam logic [8:0] REC_MS_2 = 9'h080;
  localparam logic [8:0] REC_MS_3 = 9'h100;

  // serial frame: 7 address bits, read flag, 8 data bits
  localparam logic [4:0] BIT_LAST_HDR = 5'h07;
  localparam logic [4:0] BIT_LAST     = 5'h0f;
  localparam logic [4:0] BIT_DONE     = 5'h10;
endpackage : rlc_pkg

// ---- logic/rlc_reg_if.sv ----
/*
  rlc_reg_if: internal register access between serial slave and register file.
  Assumes: one clock; wr and rd are one-cycle pulses; rdata is valid during rd.
*/
`timescale 1ns/100ps
`default_nettype none
interface rlc_reg_if;
  logic       wr;
  logic       rd;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output wr, rd, addr, wdata, input rdata);
  modport slave  (input wr, rd, addr, wdata, output rdata);
endinterface : rlc_reg_if
`default_nettype wire

// ---- logic/rlc_spi_slave.sv ----
/*
  rlc_spi_slave: serial control port, sampled on the system clock.
  Assumes: serial clock half period of at least four system clocks; latch low frames a transfer.
*/
`timescale 1ns/100ps
`default_nettype none
module rlc_spi_slave (
  input  wire logic   clock_i,
  input  wire logic   reset_n_i,
  input  wire logic   ce_i,
  input  wire logic   cclk_i,
  input  wire logic   clatch_n_i,
  input  wire logic   cdata_i,
  output logic        cdata_o,
  rlc_reg_if.master   bus
);
  import rlc_pkg::*;
  logic [2:0]  clk_s_q;
  logic [1:0]  lat_s_q;
  logic [1:0]  din_s_q;
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [7:0]  out_q;
  wire         rise   = clk_s_q[1] & ~clk_s_q[2];
  wire         fall   = ~clk_s_q[1] & clk_s_q[2];
  wire         framed = ~lat_s_q[1];
  wire         bit_in = din_s_q[1];
  wire         hdr_rd = framed & rise & (bit_cnt_q == BIT_LAST_HDR) & bit_in;
  wire         dat_wr = framed & rise & (bit_cnt_q == BIT_LAST) & ~shift_q[7];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_s_q <= 3'h0;
      lat_s_q <= 2'h3;
      din_s_q <= 2'h0;
    end else if (ce_i) begin
      clk_s_q <= {clk_s_q[1:0], cclk_i};
      lat_s_q <= {lat_s_q[0], clatch_n_i};
      din_s_q <= {din_s_q[0], cdata_i};
    end
  end

  // a dropped latch abandons the frame; extra clocks after bit 16 are ignored
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 15'h0000;
    end else if (ce_i) begin
      if (!framed) begin
        bit_cnt_q <= 5'h00;
      end else if (rise && bit_cnt_q != BIT_DONE) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
        shift_q   <= {shift_q[13:0], bit_in};
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 7'h00;
      bus.wdata <= 8'h00;
    end else if (ce_i) begin
      bus.wr <= dat_wr;
      bus.rd <= hdr_rd;
      if (hdr_rd) begin
        bus.addr <= shift_q[6:0];
      end
      if (dat_wr) begin
        bus.addr  <= shift_q[14:8];
        bus.wdata <= {shift_q[6:0], bit_in};
      end
    end
  end

  // read data leaves msb first on falling serial clock edges
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q   <= 8'h00;
      cdata_o <= 1'b0;
    end else if (ce_i) begin
      if (bus.rd) begin
        out_q <= bus.rdata;
      end else if (framed && fall && bit_cnt_q > BIT_LAST_HDR) begin
        cdata_o <= out_q[7];
        out_q   <= {out_q[6:0], 1'b0};
      end
    end
  end
endmodule : rlc_spi_slave
`default_nettype wire

// ---- logic/rlc_ms_tick.sv ----
/*
  rlc_ms_tick: one pulse per millisecond of audio, counted in sample strobes.
  Assumes: sample_valid_i pulses once per ADC sample on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module rlc_ms_tick (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  input  wire logic       clear_i,
  input  wire logic       sample_valid_i,
  input  wire logic [1:0] rate_i,
  output logic            tick_o
);
  import rlc_pkg::*;
  logic [6:0] cnt_q;
  wire  [6:0] spms = (rate_i == RATE_96) ? SPMS_96 :
                     (rate_i == RATE_48) ? SPMS_48 : SPMS_32;
  wire        rate_ok = (rate_i != RATE_RSVD);
  wire        wrap    = (cnt_q == spms - 7'h01);

  // reserved rate has no time base, so the controller stands still
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= 7'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (clear_i || !rate_ok) begin
        cnt_q <= 7'h00;
      end else if (sample_valid_i) begin
        cnt_q  <= wrap ? 7'h00 : cnt_q + 7'h01;
        tick_o <= wrap;
      end
    end
  end
endmodule : rlc_ms_tick
`default_nettype wire

// ---- logic/rlc_level_control.sv ----
/*
  rlc_level_control: record-path automatic level control with its control registers.
  Assumes: levels are dB below full scale from ADC logic on this clock, held between strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module rlc_level_control #(
  parameter int GAIN_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  input  wire logic              cclk_i,
  input  wire logic              clatch_n_i,
  input  wire logic              cdata_i,
  output logic                   cdata_o,
  input  wire logic              sample_valid_i,
  input  wire logic [7:0]        level_left_i,
  input  wire logic [7:0]        level_right_i,
  output logic [GAIN_W-1:0]      gain_reduction_o
);
  import rlc_pkg::*;

  rlc_reg_if bus ();

  logic [7:0]        cfg_a_q;
  logic [7:0]        cfg_b_q;
  logic [7:0]        lvl_l_q;
  logic [7:0]        lvl_r_q;
  logic [8:0]        atk_ms_q;
  logic [8:0]        rec_ms_q;
  logic [4:0]        steps_q;
  logic [GAIN_W-1:0] gain_q;
  logic              ms_tick;

  rlc_spi_slave u_port (
    .clock_i    (clock_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .cclk_i     (cclk_i),
    .clatch_n_i (clatch_n_i),
    .cdata_i    (cdata_i),
    .cdata_o    (cdata_o),
    .bus        (bus.master)
  );

  // register decode; the port only pulses wr and rd for one clock,
  // so each decode below lasts exactly one cycle
  wire wr_a    = bus.wr & (bus.addr == ADDR_CFG_A);
  wire wr_b    = bus.wr & (bus.addr == ADDR_CFG_B);
  wire restart = bus.wr & (bus.addr == ADDR_RESTART);

  // config fields
  wire [1:0] alc_rate_select       = cfg_a_q[RATE_LSB +: 2];
  wire [1:0] recovery_count_limit  = cfg_a_q[LIMIT_LSB +: 2];
  wire [1:0] recovery_mode_select  = cfg_a_q[MODE_LSB +: 2];
  wire       channel_detect_policy = cfg_a_q[POLICY_BIT];
  wire       level_control_enable  = cfg_a_q[ENABLE_BIT];
  wire [1:0] recovery_threshold    = cfg_b_q[RTH_LSB +: 2];
  wire [1:0] attack_threshold      = cfg_b_q[ATH_LSB +: 2];
  wire [1:0] recovery_time_select  = cfg_b_q[RTIME_LSB +: 2];
  wire       attack_time_select    = cfg_b_q[ATIME_BIT];

  // code to value selection
  wire [7:0] atk_db = (attack_threshold == 2'h0) ? ATK_DB_0 :
                      (attack_threshold == 2'h1) ? ATK_DB_1 :
                      (attack_threshold == 2'h2) ? ATK_DB_2 : ATK_DB_3;
  wire [7:0] rec_db = (recovery_threshold == 2'h0) ? REC_DB_0 :
                      (recovery_threshold == 2'h1) ? REC_DB_1 :
                      (recovery_threshold == 2'h2) ? REC_DB_2 : REC_DB_3;
  wire [8:0] atk_len = attack_time_select ? ATK_MS_1 : ATK_MS_0;
  wire [8:0] rec_len = (recovery_time_select == 2'h0) ? REC_MS_0 :
                       (recovery_time_select == 2'h1) ? REC_MS_1 :
                       (recovery_time_select == 2'h2) ? REC_MS_2 : REC_MS_3;
  wire [4:0] limit_val = (recovery_count_limit == 2'h0) ? LIMIT_0 :
                         (recovery_count_limit == 2'h1) ? LIMIT_1 :
                         (recovery_count_limit == 2'h2) ? LIMIT_2 : LIMIT_3;
  wire [8:0] atk_last = atk_len - 9'h001;
  wire [8:0] rec_last = rec_len - 9'h001;

  // level detection; smaller figure means louder
  // between the two thresholds neither timer runs: a hysteresis band
  wire l_over = (lvl_l_q <= atk_db);
  wire r_over = (lvl_r_q <= atk_db);
  wire l_hot  = (lvl_l_q < rec_db);
  wire r_hot  = (lvl_r_q < rec_db);
  wire over   = channel_detect_policy ? (l_over & r_over) : (l_over | r_over);
  wire hot    = channel_detect_policy ? (l_hot & r_hot) : (l_hot | r_hot);
  wire quiet  = ~hot & ~over;

  // disable and restart both drop the controller back to unity gain
  wire clr       = restart | ~level_control_enable;
  wire atk_fire  = ms_tick & over & (atk_ms_q == atk_last);
  wire rec_fire  = ms_tick & quiet & (rec_ms_q == rec_last);
  wire is_normal = (recovery_mode_select == MODE_NORMAL);
  wire is_limit  = (recovery_mode_select == MODE_LIMITED);
  wire rec_ok    = is_normal | (is_limit & (steps_q < limit_val));
  wire gain_max  = &gain_q;
  wire gain_zero = ~|gain_q;
  wire rec_step  = rec_fire & rec_ok & ~gain_zero;

  // reserved bit reads zero, unmapped addresses read zero
  assign bus.rdata = (bus.addr == ADDR_CFG_A)   ? cfg_a_q :
                     (bus.addr == ADDR_CFG_B)   ? cfg_b_q :
                     (bus.addr == ADDR_RESTART) ? gain_q[7:0] : RDATA_NONE;
  assign gain_reduction_o = gain_q;

  rlc_ms_tick u_tick (
    .clock_i        (clock_i),
    .reset_n_i      (reset_n_i),
    .ce_i           (ce_i),
    .clear_i        (clr),
    .sample_valid_i (sample_valid_i),
    .rate_i         (alc_rate_select),
    .tick_o         (ms_tick)
  );

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_a_q <= CFG_A_RESET;
      cfg_b_q <= CFG_B_RESET;
    end else if (ce_i) begin
      if (wr_a) begin
        cfg_a_q <= bus.wdata;
      end
      if (wr_b) begin
        cfg_b_q <= {1'b0, bus.wdata[RESV_BIT-1:0]};
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_l_q <= LEVEL_QUIET;
      lvl_r_q <= LEVEL_QUIET;
    end else if (ce_i && sample_valid_i) begin
      lvl_l_q <= level_left_i;
      lvl_r_q <= level_right_i;
    end
  end

  // timers run in whole milliseconds and restart whenever the condition breaks
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      atk_ms_q <= 9'h000;
      rec_ms_q <= 9'h000;
    end else if (ce_i) begin
      if (clr) begin
        atk_ms_q <= 9'h000;
        rec_ms_q <= 9'h000;
      end else if (ms_tick) begin
        atk_ms_q <= (over && !atk_fire) ? atk_ms_q + 9'h001 : 9'h000;
        rec_ms_q <= (quiet && !rec_fire) ? rec_ms_q + 9'h001 : 9'h000;
      end
    end
  end

  // gain in 1 dB steps; an attack resets the limited-recovery budget
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_q  <= '0;
      steps_q <= 5'h00;
    end else if (ce_i) begin
      if (clr) begin
        gain_q  <= '0;
        steps_q <= 5'h00;
      end else if (atk_fire) begin
        gain_q  <= gain_max ? gain_q : gain_q + 1'b1;
        steps_q <= 5'h00;
      end else if (rec_step) begin
        gain_q <= gain_q - 1'b1;
        if (is_limit) begin
          steps_q <= steps_q + 5'h01;
        end
      end
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  a_cfg_a_write: assert property (
    (ce_i && wr_a) |=> (cfg_a_q == $past(bus.wdata))
  ) else $error("config a write not stored");

  a_cfg_b_reserved: assert property (
    (ce_i && wr_b) |=> (cfg_b_q == {1'b0, $past(bus.wdata[6:0])}) && !cfg_b_q[7]
  ) else $error("config b write or reserved bit wrong");

  a_restart_clears: assert property (
    (ce_i && restart) |=> (gain_q == '0) && (atk_ms_q == 9'h000)
  ) else $error("restart did not clear controller");

  a_restart_read: assert property (
    (bus.rd && bus.addr == ADDR_RESTART) |-> (bus.rdata == gain_q[7:0])
  ) else $error("restart read not gain reduction");

  a_disable_unity: assert property (
    (ce_i && !level_control_enable) [*2] |-> (gain_q == '0) && (rec_ms_q == 9'h000)
  ) else $error("disabled controller holds gain");

  a_rate_reserved: assert property (
    (alc_rate_select == RATE_RSVD) [*2] |-> !ms_tick
  ) else $error("time base runs at reserved rate");

  a_no_recovery: assert property (
    (ce_i && !clr && recovery_mode_select == MODE_NONE) |=> (gain_q >= $past(gain_q))
  ) else $error("gain recovered with recovery off");

  a_limit_bound: assert property (
    is_limit |-> (steps_q <= limit_val) || $changed(recovery_count_limit)
  ) else $error("limited recovery passed its limit");

  a_both_policy: assert property (
    (ce_i && !clr && ms_tick && channel_detect_policy && !(l_over && r_over)) |=> (atk_ms_q == 9'h000)
  ) else $error("single channel advanced attack in both mode");

  a_attack_step: assert property (
    (ce_i && !clr && atk_fire && !gain_max) |=> (gain_q == $past(gain_q) + 1'b1)
  ) else $error("attack did not add one step");

  a_attack_time: assert property (
    atk_fire |-> (atk_ms_q == atk_last) && (atk_last < 9'h004)
  ) else $error("attack fired off its time");

  a_threshold_gate: assert property (
    (ce_i && ms_tick && !clr && lvl_l_q > atk_db && lvl_r_q > atk_db) |=> (atk_ms_q == 9'h000)
  ) else $error("attack timer ran below threshold");

  // second set: tick rate, timers, gates, policy, enable, step sizes, budgets and read paths
  // limit is only re-read on the next recovery, so a lowered limit is tolerated
  a_tick_rate: assert property (
    ms_tick |-> ($past(alc_rate_select) != RATE_RSVD)
  ) else $error("tick produced at reserved rate");

  a_recovery_step: assert property (
    (ce_i && !clr && !atk_fire && rec_step) |=> (gain_q == $past(gain_q) - 1'b1)
  ) else $error("recovery did not remove one step");

  a_recovery_time: assert property (
    rec_fire |-> (rec_ms_q == rec_last)
  ) else $error("recovery fired off its time");

  a_quiet_gate: assert property (
    (ce_i && ms_tick && !clr && !quiet) |=> (rec_ms_q == 9'h000)
  ) else $error("recovery timer ran above threshold");

  a_limit_hold: assert property (
    (ce_i && !clr && !atk_fire && is_limit && steps_q >= limit_val) |=> (gain_q == $past(gain_q))
  ) else $error("limited recovery went past its budget");

  a_either_policy: assert property (
    (ce_i && !clr && ms_tick && !channel_detect_policy && (l_over || r_over) && !atk_fire)
      |=> (atk_ms_q == $past(atk_ms_q) + 9'h001)
  ) else $error("single channel did not advance attack in either mode");

  a_restart_budget: assert property (
    (ce_i && restart) |=> (steps_q == 5'h00) && (rec_ms_q == 9'h000)
  ) else $error("restart left recovery state behind");

  a_reserved_read: assert property (
    (bus.rd && bus.addr == ADDR_CFG_B) |-> !bus.rdata[RESV_BIT]
  ) else $error("reserved bit read back set");

  a_cfg_a_read: assert property (
    (bus.rd && bus.addr == ADDR_CFG_A) |-> (bus.rdata == cfg_a_q)
  ) else $error("config a read wrong");

  a_attack_budget: assert property (
    (ce_i && !clr && atk_fire) |=> (steps_q == 5'h00)
  ) else $error("attack did not renew recovery budget");

  a_gain_saturate: assert property (
    (ce_i && !clr && atk_fire && gain_max) |=> gain_max
  ) else $error("gain wrapped past full reduction");

  a_disabled_unity: assert property (
    (ce_i && !level_control_enable) |=> (gain_q == '0)
  ) else $error("disable did not return to unity");


  c_attack: cover property (ce_i && atk_fire && !clr);
  c_recover: cover property (ce_i && rec_step && !clr);
  c_limit_hit: cover property (is_limit && rec_fire && steps_q == limit_val);
  c_restart: cover property (restart && !gain_zero);
  c_policy_both: cover property (ms_tick && channel_detect_policy && l_over && !r_over);
endmodule : rlc_level_control
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
  tb_top: self-checking bench for the record-path level control block.
  Assumes: rlc_pkg and the design files are compiled first; the clock is 50 MHz
  and every input is driven at the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import rlc_pkg::*;
  logic       clock_i;
  logic       reset_n_i;
  logic       ce_i;
  logic       cclk_i;
  logic       clatch_n_i;
  logic       cdata_i;
  logic       cdata_o;
  logic       sample_valid_i;
  logic [7:0] level_left_i;
  logic [7:0] level_right_i;
  logic [7:0] gain_reduction_o;
  int         err_total;
  int         checks_done;

  rlc_level_control #(.GAIN_W(8)) uut (
    .clock_i          (clock_i),
    .reset_n_i        (reset_n_i),
    .ce_i             (ce_i),
    .cclk_i           (cclk_i),
    .clatch_n_i       (clatch_n_i),
    .cdata_i          (cdata_i),
    .cdata_o          (cdata_o),
    .sample_valid_i   (sample_valid_i),
    .level_left_i     (level_left_i),
    .level_right_i    (level_right_i),
    .gain_reduction_o (gain_reduction_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic test_done();
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // half period of five clocks keeps clear of the four-clock minimum
  task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] sh;
    sh = {a, rw, d};
    q = 8'h00;
    @(negedge clock_i);
    clatch_n_i = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clock_i);
      cclk_i = 1'b0;
      cdata_i = sh[i];
      repeat (5) @(negedge clock_i);
      if (i < 8) q[i] = cdata_o;
      cclk_i = 1'b1;
      repeat (4) @(negedge clock_i);
    end
    @(negedge clock_i);
    cclk_i = 1'b0;
    repeat (5) @(negedge clock_i);
    clatch_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
  endtask : frame

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(a, 1'b0, d, q);
  endtask : wr

  task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] ex);
    logic [7:0] q;
    frame(a, 1'b1, 8'h00, q);
    `CHK(nm, ex, q)
  endtask : rd

  task automatic samples(input int n);
    repeat (n) begin
      @(negedge clock_i);
      sample_valid_i = 1'b1;
      @(negedge clock_i);
      sample_valid_i = 1'b0;
    end
  endtask : samples

  task automatic gain(input logic [7:0] ex);
    `CHK("gain port", ex, gain_reduction_o)
    rd("gain read", ADDR_RESTART, ex);
  endtask : gain

  // passing through disabled clears timers so tick phase is known
  task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] l, input logic [7:0] r);
    wr(ADDR_CFG_A, 8'h00);
    level_left_i = l;
    level_right_i = r;
    wr(ADDR_CFG_B, b);
    wr(ADDR_CFG_A, a);
  endtask : cfg

  task automatic t_regs();
    rd("cfg a reset", ADDR_CFG_A, CFG_A_RESET);
    rd("cfg b reset", ADDR_CFG_B, CFG_B_RESET);
    wr(ADDR_CFG_A, 8'hb6);
    rd("cfg a", ADDR_CFG_A, 8'hb6);
    wr(ADDR_CFG_B, 8'hff);
    rd("cfg b resv", ADDR_CFG_B, 8'h7f);
    wr(7'h10, 8'h55);
    rd("unmapped", 7'h10, 8'h00);
    wr(ADDR_RESTART, 8'h5a);
    rd("cfg a kept", ADDR_CFG_A, 8'hb6);
    gain(8'h00);
  endtask : t_regs

  task automatic t_attack();
    cfg(8'h85, 8'h00, 8'h00, 8'h00);
    samples(144);
    gain(8'h04);
    wr(ADDR_RESTART, 8'h00);
    gain(8'h00);
  endtask : t_attack

  task automatic t_policy();
    cfg(8'h87, 8'h00, 8'h00, 8'hff);
    samples(80);
    gain(8'h00);
    cfg(8'h85, 8'h00, 8'h00, 8'hff);
    samples(80);
    gain(8'h02);
  endtask : t_policy

  task automatic t_thresh();
    cfg(8'h85, 8'h19, 8'h05, 8'h05);
    samples(320);
    gain(8'h00);
    cfg(8'h85, 8'h19, 8'h04, 8'h04);
    samples(144);
    gain(8'h01);
  endtask : t_thresh

  task automatic t_recover();
    cfg(8'h85, 8'h00, 8'h00, 8'h00);
    samples(144);
    gain(8'h04);
    level_left_i = 8'hff;
    level_right_i = 8'hff;
    samples(1536);
    gain(8'h03);
  endtask : t_recover

  task automatic t_limited();
    cfg(8'h89, 8'h00, 8'h00, 8'h00);
    samples(176);
    gain(8'h05);
    level_left_i = 8'hff;
    level_right_i = 8'hff;
    samples(5632);
    gain(8'h02);
  endtask : t_limited

  task automatic t_norec();
    cfg(8'h81, 8'h00, 8'h00, 8'h00);
    samples(80);
    level_left_i = 8'hff;
    level_right_i = 8'hff;
    samples(1536);
    gain(8'h02);
  endtask : t_norec

  task automatic t_rate();
    cfg(8'h45, 8'h00, 8'h00, 8'h00);
    samples(216);
    gain(8'h04);
    cfg(8'h05, 8'h00, 8'h00, 8'h00);
    samples(432);
    gain(8'h04);
    cfg(8'hc5, 8'h00, 8'h00, 8'h00);
    samples(200);
    gain(8'h00);
  endtask : t_rate

  task automatic t_enable();
    cfg(8'h85, 8'h00, 8'h00, 8'h00);
    samples(80);
    gain(8'h02);
    wr(ADDR_CFG_A, 8'h84);
    gain(8'h00);
    samples(80);
    gain(8'h00);
  endtask : t_enable

  initial begin
    err_total = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    cclk_i = 1'b0;
    clatch_n_i = 1'b1;
    cdata_i = 1'b0;
    sample_valid_i = 1'b0;
    level_left_i = 8'hff;
    level_right_i = 8'hff;
    repeat (4) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_regs();
    t_attack();
    t_policy();
    t_thresh();
    t_recover();
    t_limited();
    t_norec();
    t_rate();
    t_enable();
    test_done();
  end

  // about twice the expected run length
  initial begin
    #1200000;
    err_total++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
